// >>> verilog/csc_pkg.sv
// What this block does
// - crystal range fuses pick four frequency modes
// - crystal start-up from low fuse and start-up fuses
// - wake delay 258, 1K or 16K cycles
// - reset adds 14 cycles plus 0/4.1/65 ms
// - RC oscillator at 4 or 8 MHz
// - RC wake 6 cycles, reset 14 plus ms
// - factory trim byte loaded at every reset
// - reset time-out always counted on watchdog oscillator
// - seven-bit trim field, zero slowest, 0x7F fastest
// - trim range 50-100, 75-150, 100-200 percent
// - source code 0000 takes external clock
// - external clock wake 6, reset 14 plus ms
// - ms delays are 512 or 8192 watchdog cycles
// - factory fuses 0100, 10, divide-by-eight programmed
package csc_pkg;

  // source-select codes
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_EXT = 4'h0;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_EXT_ALT = 4'h1;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_RC4 = 4'h2;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_RC4_ALT = 4'h3;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_RC8 = 4'h4;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_RC8_ALT = 4'h5;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_WDT = 4'h6;
  localparam int CLOCK_SOURCE_SELECT_FUSES_XTAL_BIT = 3;
  localparam logic [2:0] XTAL_R0 = 3'h4;
  localparam logic [2:0] XTAL_R1 = 3'h5;
  localparam logic [2:0] XTAL_R2 = 3'h6;
  localparam logic [2:0] XTAL_R3 = 3'h7;

  // start-up counts, oscillator cycles and watchdog cycles
  localparam int CNT_W = 16;
  localparam logic [15:0] CK_SHORT = 16'h0102;
  localparam logic [15:0] CK_1K = 16'h0400;
  localparam logic [15:0] CK_16K = 16'h4000;
  localparam logic [15:0] CK_FAST = 16'h0006;
  localparam logic [15:0] CK_RESET_EXTRA = 16'h000E;
  localparam logic [15:0] WDT_SHORT = 16'h0200;
  localparam logic [15:0] WDT_LONG = 16'h2000;
  localparam logic [15:0] WDT_NONE = 16'h0000;
  localparam int EXT_MAX_MHZ = 16;

  // register map
  localparam logic [11:0] REG_TRIM = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_FUSE = 12'h008;
  localparam logic [11:0] REG_RANGE = 12'h00C;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam int TRIM_W = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic div8_n;
    logic [1:0] sut;
    logic [3:0] clock_source_select_fuses;
  } csc_fuse_t;

  // fuse bit 0 means programmed
  localparam logic [6:0] FUSE_DEFAULT = 7'h24;

  typedef enum logic [2:0] {
    SRC_EXT = 3'h0,
    SRC_RC4 = 3'h1,
    SRC_RC8 = 3'h2,
    SRC_WDT = 3'h3,
    SRC_XTAL = 3'h4,
    SRC_NONE = 3'h5
  } csc_src_t;

  typedef enum logic [1:0] {
    RANGE_0P4 = 2'h0,
    RANGE_0P9 = 2'h1,
    RANGE_3P0 = 2'h2,
    RANGE_8P0 = 2'h3
  } csc_range_t;

  typedef enum logic [5:0] {
    ST_CAPTURE = 6'h01,
    ST_RST_MS = 6'h02,
    ST_RST_OSC = 6'h04,
    ST_RUN = 6'h08,
    ST_SLEEP = 6'h10,
    ST_WAKE = 6'h20
  } csc_state_t;

  typedef struct packed {
    logic run;
    logic reserved_sel;
    csc_src_t src;
    csc_range_t range;
    logic div8;
  } csc_status_t;

endpackage

// >>> verilog/csc_tick_counter.sv
`timescale 1ns/1ps
module csc_tick_counter #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic [W-1:0] target_i,
  // result
  output logic done_o
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic run_ff;
  logic nxt_run;

  // done is masked on the start cycle so a stale count never leaks through
  assign done_o = run_ff && !start_i && (cnt_ff == target_i);

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    if (start_i) begin
      nxt_cnt = '0;
      nxt_run = 1'b1;
    end else if (run_ff && tick_i && (cnt_ff != target_i)) begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end

endmodule

// >>> verilog/csc_top.sv
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module csc_top #(
  parameter logic [15:0] XTAL_LONG_CYCLES = csc_pkg::CK_16K,
  parameter logic [15:0] WDT_LONG_CYCLES = csc_pkg::WDT_LONG
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // fuses and factory data
  input wire csc_pkg::csc_fuse_t fuses_i,
  input wire logic [7:0] factory_trim_i,
  // oscillator ticks, one pulse per cycle of each source
  input wire logic osc_tick_i,
  input wire logic wdt_tick_i,
  // sleep request
  input wire logic power_down_i,
  // clock steering
  output logic cpu_run_o,
  output logic amp_enable_o,
  output logic ext_clock_sel_o,
  output logic rc_enable_o,
  output logic rc_8mhz_o,
  output logic start_div8_o,
  output csc_pkg::csc_range_t xtal_range_o,
  output logic [6:0] rc_trim_o,
  output logic [7:0] trim_min_pct_o,
  output logic [7:0] trim_max_pct_o,
  output csc_pkg::csc_status_t status_o,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic csc_pkg::csc_src_t decode_src(input logic [3:0] sel);
    csc_pkg::csc_src_t s;
    s = csc_pkg::SRC_NONE;
    if (sel[csc_pkg::CLOCK_SOURCE_SELECT_FUSES_XTAL_BIT]) begin
      s = csc_pkg::SRC_XTAL;
    end else begin
      unique case (sel)
        // external clock on the amplifier input
        csc_pkg::CLOCK_SOURCE_SELECT_FUSES_EXT, csc_pkg::CLOCK_SOURCE_SELECT_FUSES_EXT_ALT: s = csc_pkg::SRC_EXT;
        // internal rc at 4 or 8 mhz
        csc_pkg::CLOCK_SOURCE_SELECT_FUSES_RC4, csc_pkg::CLOCK_SOURCE_SELECT_FUSES_RC4_ALT: s = csc_pkg::SRC_RC4;
        csc_pkg::CLOCK_SOURCE_SELECT_FUSES_RC8, csc_pkg::CLOCK_SOURCE_SELECT_FUSES_RC8_ALT: s = csc_pkg::SRC_RC8;
        csc_pkg::CLOCK_SOURCE_SELECT_FUSES_WDT: s = csc_pkg::SRC_WDT;
        default: s = csc_pkg::SRC_NONE;
      endcase
    end
    return s;
  endfunction

  // wake-up delay in cycles of the selected source
  function automatic logic [15:0] wake_cycles(input csc_pkg::csc_fuse_t f,
                                              input logic [15:0] long_ck);
    logic [2:0] idx;
    logic [15:0] c;
    idx = {f.clock_source_select_fuses[0], f.sut};
    c = csc_pkg::CK_FAST;
    if (f.clock_source_select_fuses[csc_pkg::CLOCK_SOURCE_SELECT_FUSES_XTAL_BIT]) begin
      unique case (idx)
        3'h0, 3'h1: c = csc_pkg::CK_SHORT;
        3'h2, 3'h3, 3'h4: c = csc_pkg::CK_1K;
        default: c = long_ck;
      endcase
    end
    return c;
  endfunction

  // millisecond part of the reset delay in watchdog cycles
  function automatic logic [15:0] reset_ticks(input csc_pkg::csc_fuse_t f,
                                              input logic [15:0] long_wdt);
    logic [2:0] idx;
    logic [15:0] t;
    idx = {f.clock_source_select_fuses[0], f.sut};
    t = csc_pkg::WDT_NONE;
    if (f.clock_source_select_fuses[csc_pkg::CLOCK_SOURCE_SELECT_FUSES_XTAL_BIT]) begin
      // crystal table row adds none, 4.1 or 65 ms
      unique case (idx)
        3'h0, 3'h3, 3'h6: t = csc_pkg::WDT_SHORT;
        3'h1, 3'h4, 3'h7: t = long_wdt;
        default: t = csc_pkg::WDT_NONE;
      endcase
    end else begin
      unique case (f.sut)
        2'h0: t = csc_pkg::WDT_NONE;
        2'h1: t = csc_pkg::WDT_SHORT;
        // reserved code takes the longest delay, the safe side
        default: t = long_wdt;
      endcase
    end
    return t;
  endfunction

  // lower edge of the trimmed range, upper edge is twice it
  function automatic logic [7:0] pct_min(input logic [6:0] cal);
    logic [15:0] v;
    v = 16'h0000;
    if (cal <= 7'h3F) begin
      v = 16'h0032 + ((16'(cal) * 16'h0019) / 16'h003F);
    end else begin
      v = 16'h004B + ((16'(cal - 7'h3F) * 16'h0019) / 16'h0040);
    end
    return v[7:0];
  endfunction

  function automatic logic reg_hit(input logic [11:0] a);
    return (a == csc_pkg::REG_TRIM) || (a == csc_pkg::REG_STATUS) ||
           (a == csc_pkg::REG_FUSE) || (a == csc_pkg::REG_RANGE);
  endfunction

  // ---------------- start-up sequencer ----------------
  csc_pkg::csc_state_t state_ff;
  csc_pkg::csc_state_t nxt_state;
  csc_pkg::csc_fuse_t fuse_ff;
  csc_pkg::csc_fuse_t nxt_fuse;
  logic ms_start_ff;
  logic nxt_ms_start;
  logic osc_start_ff;
  logic nxt_osc_start;
  logic wake_path_ff;
  logic nxt_wake_path;
  logic ms_done;
  logic osc_done;
  logic [15:0] osc_target;
  csc_pkg::csc_src_t src;

  assign src = decode_src(fuse_ff.clock_source_select_fuses);

  // reset path adds fourteen cycles to the wake count
  assign osc_target = wake_path_ff ? wake_cycles(fuse_ff, XTAL_LONG_CYCLES) :
                      wake_cycles(fuse_ff, XTAL_LONG_CYCLES) + csc_pkg::CK_RESET_EXTRA;

  // reset time-out runs on the watchdog oscillator for every source
  csc_tick_counter #(
    .W(csc_pkg::CNT_W)
  ) u_ms_cnt (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(ms_start_ff),
    .tick_i(wdt_tick_i),
    .target_i(reset_ticks(fuse_ff, WDT_LONG_CYCLES)),
    .done_o(ms_done)
  );

  // start-up cycles counted on the selected source
  csc_tick_counter #(
    .W(csc_pkg::CNT_W)
  ) u_osc_cnt (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(osc_start_ff),
    .tick_i(osc_tick_i),
    .target_i(osc_target),
    .done_o(osc_done)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_fuse = fuse_ff;
    nxt_ms_start = 1'b0;
    nxt_osc_start = 1'b0;
    nxt_wake_path = wake_path_ff;
    unique case (state_ff)
      csc_pkg::ST_CAPTURE: begin
        // fuses are sampled after release, never through the reset itself
        nxt_fuse = fuses_i;
        nxt_ms_start = 1'b1;
        nxt_wake_path = 1'b0;
        nxt_state = csc_pkg::ST_RST_MS;
      end
      csc_pkg::ST_RST_MS: begin
        if (ms_done) begin
          nxt_osc_start = 1'b1;
          nxt_state = csc_pkg::ST_RST_OSC;
        end
      end
      csc_pkg::ST_RST_OSC: begin
        if (osc_done) begin
          nxt_state = csc_pkg::ST_RUN;
        end
      end
      csc_pkg::ST_RUN: begin
        if (power_down_i) begin
          nxt_state = csc_pkg::ST_SLEEP;
        end
      end
      csc_pkg::ST_SLEEP: begin
        if (!power_down_i) begin
          nxt_osc_start = 1'b1;
          nxt_wake_path = 1'b1;
          nxt_state = csc_pkg::ST_WAKE;
        end
      end
      csc_pkg::ST_WAKE: begin
        if (osc_done) begin
          nxt_state = csc_pkg::ST_RUN;
        end
      end
      default: nxt_state = csc_pkg::ST_CAPTURE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= csc_pkg::ST_CAPTURE;
      // factory fuse image until the real fuses are sampled
      fuse_ff <= csc_pkg::FUSE_DEFAULT;
      ms_start_ff <= 1'b0;
      osc_start_ff <= 1'b0;
      wake_path_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      fuse_ff <= nxt_fuse;
      ms_start_ff <= nxt_ms_start;
      osc_start_ff <= nxt_osc_start;
      wake_path_ff <= nxt_wake_path;
    end
  end

  // ---------------- calibration trim ----------------
  logic [6:0] trim_ff;
  logic [6:0] nxt_trim;
  logic trim_load_ff;
  logic nxt_trim_load;
  logic wr_fire;
  // write holding registers, read by the trim update below
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  always_comb begin
    nxt_trim = trim_ff;
    nxt_trim_load = 1'b0;
    if (trim_load_ff) begin
      // factory byte copied in on every reset
      nxt_trim = factory_trim_i[6:0];
    end else if (wr_fire && (awaddr_ff == csc_pkg::REG_TRIM) && wstrb_ff[0]) begin
      nxt_trim = wdata_ff[6:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trim_ff <= csc_pkg::TRIM_RESET[6:0];
      trim_load_ff <= 1'b1;
    end else begin
      trim_ff <= nxt_trim;
      trim_load_ff <= nxt_trim_load;
    end
  end

  // ---------------- outputs ----------------
  logic run_ff;
  logic nxt_run;
  csc_pkg::csc_range_t range;
  logic [7:0] trim_min;

  always_comb begin
    unique case (fuse_ff.clock_source_select_fuses[3:1])
      csc_pkg::XTAL_R0: range = csc_pkg::RANGE_0P4;
      csc_pkg::XTAL_R1: range = csc_pkg::RANGE_0P9;
      csc_pkg::XTAL_R2: range = csc_pkg::RANGE_3P0;
      csc_pkg::XTAL_R3: range = csc_pkg::RANGE_8P0;
      default: range = csc_pkg::RANGE_0P4;
    endcase
  end

  assign nxt_run = (nxt_state == csc_pkg::ST_RUN);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
    end
  end

  assign cpu_run_o = run_ff;
  assign amp_enable_o = (src == csc_pkg::SRC_XTAL);
  assign ext_clock_sel_o = (src == csc_pkg::SRC_EXT);
  // rc oscillator 4 or 8 mhz
  assign rc_enable_o = (src == csc_pkg::SRC_RC4) || (src == csc_pkg::SRC_RC8);
  assign rc_8mhz_o = (src == csc_pkg::SRC_RC8);
  assign start_div8_o = !fuse_ff.div8_n;
  assign xtal_range_o = range;
  assign rc_trim_o = trim_ff;
  assign trim_min = pct_min(trim_ff);
  assign trim_min_pct_o = trim_min;
  assign trim_max_pct_o = {trim_min[6:0], 1'b0};
  assign status_o.run = run_ff;
  assign status_o.reserved_sel = (src == csc_pkg::SRC_NONE) ||
                                 (!fuse_ff.clock_source_select_fuses[csc_pkg::CLOCK_SOURCE_SELECT_FUSES_XTAL_BIT] &&
                                  (fuse_ff.sut == 2'h3));
  assign status_o.src = src;
  assign status_o.range = range;
  assign status_o.div8 = !fuse_ff.div8_n;

  // ---------------- axi4-lite slave ----------------
  logic aw_hold_ff;
  logic nxt_aw_hold;
  logic [11:0] nxt_awaddr;
  logic w_hold_ff;
  logic nxt_w_hold;
  logic [31:0] nxt_wdata;
  logic [3:0] nxt_wstrb;
  logic bvalid_ff;
  logic nxt_bvalid;
  logic [1:0] bresp_ff;
  logic [1:0] nxt_bresp;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] rresp_ff;
  logic [1:0] nxt_rresp;

  // one write and one read in flight; address and data may come in any order
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;

  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_hold = w_hold_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = {s_axi_awaddr[11:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = reg_hit(awaddr_ff) ? csc_pkg::RESP_OKAY : csc_pkg::RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = csc_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[11:2], 2'h0})
        csc_pkg::REG_TRIM: nxt_rdata = {25'h000_0000, trim_ff};
        csc_pkg::REG_STATUS: nxt_rdata = {23'h00_0000, status_o, state_ff == csc_pkg::ST_RUN};
        csc_pkg::REG_FUSE: nxt_rdata = {25'h000_0000, fuse_ff};
        csc_pkg::REG_RANGE: nxt_rdata = {16'h0000, trim_max_pct_o, trim_min_pct_o};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = csc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      w_hold_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      awaddr_ff <= nxt_awaddr;
      w_hold_ff <= nxt_w_hold;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule

// >>> testbench/csc_osc_model.sv
`timescale 1ns/1ps
module csc_osc_model #(
  parameter int OSC_DIV = 2,
  parameter int WDT_DIV = 4
) (
  // clock
  input wire logic clk_i,
  // one-cycle ticks
  output logic osc_tick_o,
  output logic wdt_tick_o
);
  int osc_cnt = 0;
  int wdt_cnt = 0;
  initial begin
    osc_tick_o = 1'b0;
    wdt_tick_o = 1'b0;
  end
  always @(posedge clk_i) begin
    osc_cnt <= (osc_cnt + 1) % OSC_DIV;
    wdt_cnt <= (wdt_cnt + 1) % WDT_DIV;
    osc_tick_o <= (osc_cnt == OSC_DIV - 1);
    wdt_tick_o <= (wdt_cnt == WDT_DIV - 1);
  end
endmodule

// >>> testbench/csc_properties.sv
`timescale 1ns/1ps
module csc_props #(
  parameter logic [15:0] XTAL_LONG_CYCLES = csc_pkg::CK_16K,
  parameter logic [15:0] WDT_LONG_CYCLES = csc_pkg::WDT_LONG
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // inputs
  input wire csc_pkg::csc_fuse_t fuses_i,
  input wire logic [7:0] factory_trim_i,
  input wire logic osc_tick_i,
  input wire logic wdt_tick_i,
  input wire logic power_down_i,
  input wire logic s_axi_arvalid,
  // outputs
  input wire logic cpu_run_o,
  input wire logic amp_enable_o,
  input wire logic ext_clock_sel_o,
  input wire logic rc_enable_o,
  input wire logic rc_8mhz_o,
  input wire logic start_div8_o,
  input wire csc_pkg::csc_range_t xtal_range_o,
  input wire logic [6:0] rc_trim_o,
  input wire logic [7:0] trim_min_pct_o,
  input wire logic [7:0] trim_max_pct_o,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] osc_n_ff, nxt_osc_n, wdt_n_ff, nxt_wdt_n, wake_n, ms_n;
  logic ran_ff, nxt_ran;
  logic [2:0] idx;
  assign idx = {fuses_i.clock_source_select_fuses[0], fuses_i.sut};
  always_comb begin
    wake_n = 16'h0006;
    ms_n = (fuses_i.sut == 2'h0) ? 16'h0000 : (fuses_i.sut == 2'h1) ? 16'h0200 : WDT_LONG_CYCLES;
    if (fuses_i.clock_source_select_fuses[3]) begin
      wake_n = (idx < 3'h2) ? 16'h0102 : (idx < 3'h5) ? 16'h0400 : XTAL_LONG_CYCLES;
      ms_n = (idx % 3 == 0) ? 16'h0200 : (idx % 3 == 1) ? WDT_LONG_CYCLES : 16'h0000;
    end
  end
  // ticks seen while held and not asleep; cleared while running
  always_comb begin
    nxt_ran = ran_ff | cpu_run_o;
    nxt_osc_n = osc_n_ff;
    nxt_wdt_n = wdt_n_ff;
    if (cpu_run_o) begin
      nxt_osc_n = 16'h0000;
      nxt_wdt_n = 16'h0000;
    end else if (!power_down_i) begin
      nxt_osc_n = osc_n_ff + {15'h0000, osc_tick_i};
      nxt_wdt_n = wdt_n_ff + {15'h0000, wdt_tick_i};
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_n_ff <= 16'h0000;
      wdt_n_ff <= 16'h0000;
      ran_ff <= 1'b0;
    end else begin
      osc_n_ff <= nxt_osc_n;
      wdt_n_ff <= nxt_wdt_n;
      ran_ff <= nxt_ran;
    end
  end
  a_wake_span: assert property (
    $rose(cpu_run_o) && ran_ff |-> osc_n_ff >= wake_n && osc_n_ff <= wake_n + 16'h0004)
    else $error("wake count wrong");
  a_reset_span: assert property (
    $rose(cpu_run_o) && !ran_ff |-> wdt_n_ff >= ms_n && osc_n_ff >= wake_n + 16'h000E)
    else $error("reset delay short");
  a_sleep_stops: assert property (
    cpu_run_o && power_down_i |=> !cpu_run_o) else $error("run kept in sleep");
  a_xtal_range: assert property (
    cpu_run_o |-> xtal_range_o == (fuses_i.clock_source_select_fuses[3] ? fuses_i.clock_source_select_fuses[2:1] : 2'h0))
    else $error("range decode");
  a_rc_select: assert property (
    cpu_run_o |-> rc_enable_o == (fuses_i.clock_source_select_fuses inside {[4'h2:4'h5]})
    && rc_8mhz_o == (fuses_i.clock_source_select_fuses[3:1] == 3'h2)) else $error("rc decode");
  a_ext_select: assert property (
    cpu_run_o |-> ext_clock_sel_o == (fuses_i.clock_source_select_fuses[3:1] == 3'h0)
    && amp_enable_o == fuses_i.clock_source_select_fuses[3]) else $error("source decode");
  a_div8_fuse: assert property (
    cpu_run_o |-> start_div8_o == !fuses_i.div8_n) else $error("div8 decode");
  a_trim_factory: assert property (
    $fell(rst_i) |=> rc_trim_o == factory_trim_i[6:0]) else $error("trim not loaded");
  a_trim_low: assert property (
    rc_trim_o == 7'h00 |-> trim_min_pct_o == 8'h32 && trim_max_pct_o == 8'h64)
    else $error("low span");
  a_trim_top: assert property (
    rc_trim_o == 7'h7F |-> trim_min_pct_o == 8'h64 && trim_max_pct_o == 8'hC8)
    else $error("top span");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  cover property ($rose(cpu_run_o) && ran_ff);
  cover property (cpu_run_o && amp_enable_o);
  cover property (s_axi_rvalid);
endmodule

// >>> testbench/csc_top_tb.sv
`timescale 1ns/1ps
module csc_top_tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  csc_pkg::csc_fuse_t fuses_i = csc_pkg::FUSE_DEFAULT;
  logic [7:0] factory_trim_i = 8'h00;
  logic power_down_i = 1'b0;
  logic osc_tick_i, wdt_tick_i, cpu_run_o, amp_enable_o, ext_clock_sel_o;
  logic rc_enable_o, rc_8mhz_o, start_div8_o;
  csc_pkg::csc_range_t xtal_range_o;
  csc_pkg::csc_status_t status_o;
  logic [6:0] rc_trim_o;
  logic [7:0] trim_min_pct_o, trim_max_pct_o;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int fails = 0;
  int checks = 0;
  // fuse cases: 258-cycle option only with a resonator range, div8 on 8 MHz RC and on crystal cases 0x3B and 0x0F
  logic [6:0] fz [8] = '{7'h24, 7'h40, 7'h52, 7'h48, 7'h3B, 7'h6D, 7'h76, 7'h0F};
  logic [7:0] tz [8] = '{8'h11, 8'h22, 8'h3F, 8'h40, 8'h7F, 8'h01, 8'h55, 8'hBF};
  // source expected for each fuse case
  csc_pkg::csc_src_t sz [8] = '{csc_pkg::SRC_RC8, csc_pkg::SRC_EXT, csc_pkg::SRC_RC4,
                                csc_pkg::SRC_XTAL, csc_pkg::SRC_XTAL, csc_pkg::SRC_XTAL,
                                csc_pkg::SRC_WDT, csc_pkg::SRC_XTAL};
  // trim steps of 0x20 at most; no memory writes run meanwhile
  logic [31:0] wt [6] = '{32'h0000_005F, 32'h0000_00FF, 32'h0000_005F,
                          32'h0000_003F, 32'h0000_001F, 32'h0000_0000};

  // long counts shortened to keep the run short
  csc_top #(.XTAL_LONG_CYCLES(16'h0028), .WDT_LONG_CYCLES(16'h0014)) i_csc_top (.*);
  csc_osc_model i_csc_osc_model (
    .clk_i(core_clk_i),
    .osc_tick_o(osc_tick_i),
    .wdt_tick_o(wdt_tick_i)
  );

  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk_i);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge core_clk_i); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk_i); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic wait_run;
    while (cpu_run_o !== 1'b1) @(posedge core_clk_i);
  endtask

  initial begin
    @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      rst_i <= 1'b1;
      fuses_i <= fz[i];
      factory_trim_i <= tz[i];
      repeat (16) @(posedge core_clk_i);
      rst_i <= 1'b0;
      wait_run();
      chk({31'h0, amp_enable_o}, {31'h0, fz[i][3]});
      chk({30'h0, xtal_range_o}, {30'h0, fz[i][2:1] & {2{fz[i][3]}}});
      chk({31'h0, ext_clock_sel_o}, {31'h0, fz[i][3:1] == 3'h0});
      chk({31'h0, rc_enable_o}, {31'h0, fz[i][3:0] inside {[4'h2:4'h5]}});
      chk({31'h0, rc_8mhz_o}, {31'h0, fz[i][3:1] == 3'h2});
      chk({31'h0, start_div8_o}, {31'h0, !fz[i][6]});
      chk({25'h0, rc_trim_o}, {25'h0, tz[i][6:0]});
      axi_rd(csc_pkg::REG_FUSE, {25'h0, fz[i]}, csc_pkg::RESP_OKAY);
      axi_rd(csc_pkg::REG_STATUS, {23'h0, 1'b1, fz[i][5:3] == 3'h6, sz[i],
             fz[i][2:1] & {2{fz[i][3]}}, !fz[i][6], 1'b1}, csc_pkg::RESP_OKAY);
      power_down_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      chk({31'h0, cpu_run_o}, 32'h0000_0000);
      power_down_i <= 1'b0;
      wait_run();
    end
    axi_rd(csc_pkg::REG_RANGE, 32'h0000_964B, csc_pkg::RESP_OKAY);
    for (int j = 0; j < 6; j++) begin
      axi_wr(csc_pkg::REG_TRIM, wt[j], csc_pkg::RESP_OKAY);
      axi_rd(csc_pkg::REG_TRIM, wt[j] & 32'h0000_007F, csc_pkg::RESP_OKAY);
      if (j == 1) begin
        axi_rd(csc_pkg::REG_RANGE, 32'h0000_C864, csc_pkg::RESP_OKAY);
      end
    end
    axi_rd(csc_pkg::REG_RANGE, 32'h0000_6432, csc_pkg::RESP_OKAY);
    axi_wr(12'h010, 32'h0000_0001, csc_pkg::RESP_SLVERR);
    axi_rd(12'h010, 32'h0000_0000, csc_pkg::RESP_SLVERR);
    axi_wr(csc_pkg::REG_FUSE, 32'h0000_0000, csc_pkg::RESP_OKAY);
    axi_rd(csc_pkg::REG_FUSE, {25'h0, fz[7]}, csc_pkg::RESP_OKAY);
    finish_test();
  end

  // whole run needs about 13k cycles
  initial begin
    #1_600_000;
    fails++;
    finish_test();
  end
endmodule

bind csc_top csc_props #(
  .XTAL_LONG_CYCLES(XTAL_LONG_CYCLES),
  .WDT_LONG_CYCLES(WDT_LONG_CYCLES)
) i_csc_props (.*);
